/* File: jack_debounce.sv */
`timescale 1ns/1ps
module jack_debounce
  import jack_i2c_pkg::*;
#(
  parameter int debounce_count = debounce_cycles,
  parameter int detect_count = detect_cycles_default
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic jack_detect_input,
  output logic hold_writes,
  output logic inserted,
  output logic event_pulse
);

  initial begin
    if (debounce_count < 1 || detect_count < 1) begin
      $error("jack_debounce: counts must be at least one");
    end
  end

  typedef struct packed {
    jack_state_type st;
    logic last_in;
    logic [31:0] cnt;
    logic inserted;
    logic evt;
  } jack_reg_type;

  jack_reg_type s_r;
  jack_reg_type s_nxt;

  // ****************************************************************
  // debounce and detection sequencer
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.last_in = jack_detect_input;
    s_nxt.evt = 1'b0;
    unique case (s_r.st)
      jk_idle: begin
        if (s_r.last_in && !jack_detect_input) begin
          s_nxt.st = jk_debounce;
          s_nxt.cnt = 32'h0000_0000;
        end else if (!s_r.last_in && jack_detect_input && s_r.inserted) begin
          s_nxt.inserted = 1'b0;
          s_nxt.evt = 1'b1;
        end
      end
      jk_debounce: begin
        if (jack_detect_input) begin
          s_nxt.st = jk_idle;
        end else if (s_r.cnt == 32'(debounce_count - 1)) begin
          s_nxt.st = jk_detect;
          s_nxt.cnt = 32'h0000_0000;
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
      end
      jk_detect: begin
        if (s_r.cnt == 32'(detect_count - 1)) begin
          s_nxt.st = jk_idle;
          s_nxt.inserted = 1'b1;
          s_nxt.evt = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: jk_idle, last_in: 1'b1, cnt: 32'h0000_0000, inserted: 1'b0, evt: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hold_writes = (s_r.st != jk_idle);
  assign inserted = s_r.inserted;
  assign event_pulse = s_r.evt;

endmodule // jack_debounce

/* File: jack_i2c_master_model.sv */
`timescale 1ns/1ps
module jack_i2c_master_model (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  // ****************************************************************
  // master bus phases, moved only after falling clock edges
  // ****************************************************************
  initial {scl, sda} = 2'b11;
  task automatic st(input int n, input logic c, input logic d);
    repeat (n) @(negedge clk);
    scl = c;
    sda = d;
  endtask
  task automatic start();
    st(2, scl, 1'b1);
    st(3, 1'b1, 1'b1);
    st(4, 1'b1, 1'b0);
    st(4, 1'b0, 1'b0);
  endtask
  task automatic stop();
    st(2, 1'b0, 1'b0);
    st(3, 1'b1, 1'b0);
    st(4, 1'b1, 1'b1);
    st(4, 1'b1, 1'b1);
  endtask
  task automatic bt(input logic b, output logic r);
    st(2, 1'b0, b);
    st(3, 1'b1, b);
    st(2, 1'b1, b);
    r = sda_line;
    st(2, 1'b0, b);
  endtask
  // sda high releases the line for the other side
  task automatic xb(input logic [7:0] d, input logic am, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
    bt(am, a);
  endtask
endmodule // jack_i2c_master_model

/* File: jack_i2c_pkg.sv */
package jack_i2c_pkg;

  // ****************************************************************
  // bus addressing
  // ****************************************************************
  localparam logic [6:0] slave_addr = 7'h3b;
  localparam logic [6:0] general_call_addr = 7'h00;
  localparam int reg_count = 16;
  localparam int ptr_width = 4;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int clk_mhz = 125;
  localparam int debounce_ms = 90;
  localparam int debounce_cycles = debounce_ms * 1000 * clk_mhz;
  localparam int detect_cycles_default = 1000;

  // ****************************************************************
  // register file read-only mask and reset value
  // ****************************************************************
  localparam logic [reg_count-1:0] read_only_mask = 16'h0f00;
  localparam logic [7:0] reg_reset_value = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum {
    st_idle,
    st_addr,
    st_addr_ack,
    st_ptr,
    st_ptr_ack,
    st_wdata,
    st_wdata_ack,
    st_rdata,
    st_rdata_ack
  } i2c_state_type;

  typedef enum {
    jk_idle,
    jk_debounce,
    jk_detect
  } jack_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_pins_type;

  typedef struct packed {
    logic valid;
    logic [ptr_width-1:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage

/* File: jack_i2c_slave.sv */
`timescale 1ns/1ps
// Contract
// - first byte is seven-bit address plus direction bit, MSB first
// - general call address is ignored and not acknowledged
// - acknowledge only 0x76 write or 0x77 read, SDA low at ack clock
// - only complete acknowledged bytes take effect; partial bytes dropped
// - SDA change while SCL high is START or STOP
// - every byte followed by one ack bit; byte count unlimited
// - transmitter releases SDA before the ack bit
// - addressed receiver acknowledges every byte, low through ack high phase
// - write: byte after address is pointer; next byte stored at ack rise
// - read: pointer write, restart, read address; data loaded at ack rise
// - pointer survives STOP and new START
// - single mode write repeats into same register until STOP or restart
// - single mode read repeats same register until NACK
// - burst write increments pointer, acks read-only writes without change
// - burst read increments pointer after each byte until NACK
// - jack-detect falling edge starts 90 ms debounce, then detection
// - register writes deferred while debounce and detection run; one pending slot, so a later write replaces an earlier held one
// - jack-detect rising before expiry releases pending writes
// - insertion status updated when insertion or removal processed
module jack_i2c_slave
  import jack_i2c_pkg::*;
#(
  parameter bit auto_inc_write = 1'b1,
  parameter bit auto_inc_read = 1'b1,
  parameter int debounce_count = debounce_cycles,
  parameter int detect_count = detect_cycles_default
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic jack_detect_input,
  input wire logic [7:0] status_in [reg_count],
  output logic [7:0] ctrl_out [reg_count],
  output logic insertion_status,
  output logic ins_rem_event
);

  initial begin
    if (!(debounce_count >= 1 && detect_count >= 1)) begin
      $error("jack_i2c_slave: bad counts");
    end
    if (reg_count > (1 << ptr_width)) begin
      $error("jack_i2c_slave: pointer too narrow for register count");
    end
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************************************
  // jack detect sequencer
  // ****************************************************************
  logic hold_writes;

  jack_debounce #(
    .debounce_count(debounce_count),
    .detect_count(detect_count)
  ) u_debounce (
    .clk(clk),
    .rst_n(rst_n),
    .jack_detect_input(jack_detect_input),
    .hold_writes(hold_writes),
    .inserted(insertion_status),
    .event_pulse(ins_rem_event)
  );

  // ****************************************************************
  // i2c protocol state
  // ****************************************************************
  typedef struct packed {
    i2c_state_type st;
    i2c_pins_type last;
    logic [7:0] shift;
    logic [2:0] bitn;
    logic [ptr_width-1:0] ptr;
    logic rw;
    logic drive_low;
    logic full;
    reg_write_type pend;
  } slave_reg_type;

  slave_reg_type s_r;
  slave_reg_type s_nxt;
  logic [7:0] regs_r [reg_count];

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // ****************************************************************
  // bus edge and condition detect
  // ****************************************************************
  assign scl_rise = !s_r.last.scl && scl_in;
  assign scl_fall = s_r.last.scl && !scl_in;
  assign start_cond = s_r.last.scl && scl_in && s_r.last.sda && !sda_in;
  assign stop_cond = s_r.last.scl && scl_in && !s_r.last.sda && sda_in;

  // ****************************************************************
  // byte receive, acknowledge and transmit
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.last = '{scl: scl_in, sda: sda_in};
    if (!hold_writes && s_r.pend.valid) begin
      s_nxt.pend.valid = 1'b0;
    end
    if (start_cond) begin
      s_nxt.st = st_addr;
      s_nxt.bitn = 3'h0;
      s_nxt.full = 1'b0;
      s_nxt.drive_low = 1'b0;
    end else if (stop_cond) begin
      s_nxt.st = st_idle;
      s_nxt.drive_low = 1'b0;
    end else begin
      unique case (s_r.st)
        st_idle: begin
        end
        st_addr, st_ptr, st_wdata: begin
          if (scl_rise) begin
            s_nxt.shift = {s_r.shift[6:0], sda_in};
            s_nxt.bitn = s_r.bitn + 3'h1;
            s_nxt.full = (s_r.bitn == 3'h7);
          end else if (scl_fall && s_r.full) begin
            // eighth bit done: decide ack; the fall that follows START holds no byte
            s_nxt.full = 1'b0;
            if (s_r.st == st_addr) begin
              if (s_r.shift[7:1] == slave_addr && s_r.shift[7:1] != general_call_addr) begin
                s_nxt.rw = s_r.shift[0];
                s_nxt.drive_low = 1'b1;
                s_nxt.st = st_addr_ack;
              end else begin
                s_nxt.st = st_idle;
              end
            end else begin
              s_nxt.drive_low = 1'b1;
              s_nxt.st = (s_r.st == st_ptr) ? st_ptr_ack : st_wdata_ack;
            end
          end
        end
        st_addr_ack, st_ptr_ack, st_wdata_ack: begin
          if (scl_rise) begin
            if (s_r.st == st_ptr_ack) begin
              s_nxt.ptr = s_r.shift[ptr_width-1:0];
            end else if (s_r.st == st_wdata_ack) begin
              s_nxt.pend = '{valid: 1'b1, addr: s_r.ptr, data: s_r.shift};
              if (auto_inc_write) begin
                s_nxt.ptr = s_r.ptr + 1'b1;
              end
            end else if (s_r.rw) begin
              s_nxt.shift = regs_r[s_r.ptr];
            end
          end else if (scl_fall) begin
            s_nxt.bitn = 3'h0;
            if (s_r.st == st_addr_ack && s_r.rw) begin
              s_nxt.st = st_rdata;
              s_nxt.drive_low = !s_r.shift[7];
            end else begin
              s_nxt.drive_low = 1'b0;
              s_nxt.st = (s_r.st == st_addr_ack) ? st_ptr : st_wdata;
            end
          end
        end
        st_rdata: begin
          if (scl_rise) begin
            s_nxt.bitn = s_r.bitn + 3'h1;
          end else if (scl_fall) begin
            if (s_r.bitn == 3'h0) begin
              s_nxt.drive_low = 1'b0;
              s_nxt.st = st_rdata_ack;
            end else begin
              s_nxt.drive_low = !s_r.shift[3'h7 - s_r.bitn];
            end
          end
        end
        st_rdata_ack: begin
          if (scl_rise) begin
            if (sda_in) begin
              s_nxt.st = st_idle;
            end else begin
              if (auto_inc_read) begin
                s_nxt.ptr = s_r.ptr + 1'b1;
                s_nxt.shift = regs_r[s_r.ptr + 1'b1];
              end else begin
                s_nxt.shift = regs_r[s_r.ptr];
              end
            end
          end else if (scl_fall) begin
            s_nxt.bitn = 3'h0;
            s_nxt.st = st_rdata;
            s_nxt.drive_low = !s_r.shift[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: st_idle, last: '{scl: 1'b1, sda: 1'b1}, shift: 8'h00, bitn: 3'h0,
               ptr: '0, rw: 1'b0, drive_low: 1'b0, full: 1'b0,
               pend: '{valid: 1'b0, addr: '0, data: 8'h00}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < reg_count; gi++) begin : g_reg
      if (read_only_mask[gi]) begin : g_ro
        assign regs_r[gi] = status_in[gi];
      end else begin : g_rw
        logic [7:0] val_r;
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            val_r <= reg_reset_value;
          end else if (s_r.pend.valid && !hold_writes && s_r.pend.addr == ptr_width'(gi)) begin
            val_r <= s_r.pend.data;
          end
        end
        assign regs_r[gi] = val_r;
      end
      assign ctrl_out[gi] = regs_r[gi];
    end
  endgenerate

  // ****************************************************************
  // open-drain data pin
  // ****************************************************************
  assign sda_out = 1'b0;
  assign sda_oe_n = !s_r.drive_low;

endmodule // jack_i2c_slave

/* File: jack_i2c_slave_chk.sv */
`timescale 1ns/1ps
module jack_i2c_slave_chk
  import jack_i2c_pkg::*;
#(
  parameter int debounce_count = 50,
  parameter int detect_count = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic jack_detect_input,
  input wire logic [7:0] ctrl_out [reg_count],
  input wire logic insertion_status,
  input wire logic ins_rem_event
);
  // ****************************************************************
  // wire decode: bit count, address match, direction
  // ****************************************************************
  localparam int dd = debounce_count + detect_count;
  logic scl_r, sda_r, first_r, hit_r, wr_r, ack_rise, held;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [8*reg_count-1:0] ctrl_flat;
  int low_r;
  assign ctrl_flat = {>>{ctrl_out}};
  assign ack_rise = scl_in && !scl_r && bit_r == 4'h8;
  assign held = !jack_detect_input && !insertion_status && low_r > 4 && low_r < dd;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {scl_r, sda_r, first_r, hit_r, wr_r} <= 5'h18;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      low_r <= 0;
    end else begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      low_r <= jack_detect_input ? 0 : low_r + 1;
      if (scl_in && scl_r && sda_r != sda_in) begin
        bit_r <= 4'h0;
        first_r <= !sda_in;
        hit_r <= 1'b0;
      end else if (scl_in && !scl_r) begin
        bit_r <= ack_rise ? 4'h0 : bit_r + 4'h1;
        if (!ack_rise) begin
          sh_r <= {sh_r[6:0], sda_in};
        end else if (first_r) begin
          hit_r <= sh_r[7:1] == slave_addr;
          wr_r <= !sh_r[0];
          first_r <= 1'b0;
        end
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence addr_slot;
    ack_rise && first_r;
  endsequence
  sequence data_slot;
    ack_rise && !first_r && hit_r;
  endsequence
  addr_ack_a: assert property (addr_slot |-> sda_oe_n == (sh_r[7:1] != slave_addr))
    else $error("address acknowledge wrong");
  write_ack_a: assert property (data_slot ##0 wr_r |-> !sda_oe_n)
    else $error("write byte not acknowledged");
  read_release_a: assert property (data_slot ##0 !wr_r |-> sda_oe_n)
    else $error("data line held at master acknowledge");
  quiet_bus_a: assert property (!hit_r && !(first_r && bit_r == 4'h8) |-> sda_oe_n)
    else $error("data line driven while not addressed");
  sda_steady_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  debounce_time_a: assert property ($rose(insertion_status) |-> low_r >= dd && low_r <= dd + 12)
    else $error("insertion declared at wrong time");
  hold_regs_a: assert property (held && $past(held) |-> $stable(ctrl_flat))
    else $error("register changed during debounce");
  status_event_a: assert property ($changed(insertion_status) |-> ins_rem_event || $past(ins_rem_event))
    else $error("status change without event");
endmodule // jack_i2c_slave_chk
bind jack_i2c_slave jack_i2c_slave_chk #(
  .debounce_count(debounce_count),
  .detect_count(detect_count)
) u_chk (
  .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .jack_detect_input(jack_detect_input), .ctrl_out(ctrl_out),
  .insertion_status(insertion_status), .ins_rem_event(ins_rem_event)
);

/* File: jack_i2c_slave_tb_top.sv */
`timescale 1ns/1ps
module jack_i2c_slave_tb_top
  import jack_i2c_pkg::*;
;
  // ****************************************************************
  // burst write rows, read back across the read-only indices
  // ****************************************************************
  localparam int deb_n = 2000;
  localparam int det_n = 100;
  typedef struct packed {logic [7:0] p, d0, d1, e0, e1;} row_type;
  localparam row_type rows [4] = '{'{8'h00, 8'h11, 8'h22, 8'h11, 8'h22},
    '{8'h07, 8'h33, 8'h44, 8'h33, 8'ha8}, '{8'h0b, 8'h55, 8'h66, 8'hab, 8'h66},
    '{8'h05, 8'hff, 8'h00, 8'hff, 8'h00}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic jack_detect_input = 1'b1;
  logic sda_out, sda_oe_n, insertion_status, ins_rem_event, m_scl, m_sda, sda_line, a;
  logic [7:0] status_in [reg_count];
  logic [7:0] ctrl_out [reg_count];
  int failures = 0;
  int n_compared = 0;
  assign sda_line = m_sda & (sda_oe_n | sda_out);
  always #4 clk = ~clk;
  initial for (int i = 0; i < reg_count; i++) status_in[i] = 8'ha0 + 8'(i);
  jack_i2c_slave #(.debounce_count(deb_n), .detect_count(det_n)) u_dut (
    .clk(clk), .reset_n(reset_n), .scl_in(m_scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .jack_detect_input(jack_detect_input), .status_in(status_in),
    .ctrl_out(ctrl_out), .insertion_status(insertion_status), .ins_rem_event(ins_rem_event));
  jack_i2c_master_model u_mst (.clk(clk), .sda_line(sda_line), .scl(m_scl), .sda(m_sda));
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xf(input logic [7:0] d, input logic am, input logic [8:0] exp);
    logic [7:0] r;
    logic ack;
    u_mst.xb(d, am, r, ack);
    chk("byte", {r, ack}, exp);
  endtask
  task automatic wb(input logic [7:0] d);
    xf(d, 1'b1, {d, 1'b0});
  endtask
  task automatic hdr(input logic [7:0] p);
    u_mst.start();
    wb(8'h76);
    wb(p);
  endtask
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < reg_count; i++)
      if (!read_only_mask[i]) chk("reset", {1'b0, ctrl_out[i]}, {1'b0, reg_reset_value});
    foreach (rows[i]) begin
      hdr(rows[i].p);
      wb(rows[i].d0);
      wb(rows[i].d1);
      u_mst.stop();
      hdr(rows[i].p);
      u_mst.start();
      wb(8'h77);
      xf(8'hff, 1'b0, {rows[i].e0, 1'b0});
      xf(8'hff, 1'b1, {rows[i].e1, 1'b1});
      u_mst.stop();
    end
    u_mst.start();
    xf(8'h00, 1'b1, 9'h001);
    u_mst.start();
    xf(8'h74, 1'b1, 9'h0e9);
    hdr(8'h01);
    repeat (4) u_mst.bt(1'b0, a);
    u_mst.stop();
    chk("partial", {1'b0, ctrl_out[1]}, 9'h022);
    hdr(8'h05);
    u_mst.stop();
    u_mst.start();
    wb(8'h77);
    xf(8'hff, 1'b1, 9'h1ff);
    u_mst.stop();
    // write sent while debounce runs, lands after detection
    jack_detect_input = 1'b0;
    hdr(8'h01);
    wb(8'h5a);
    u_mst.stop();
    chk("held", {1'b0, ctrl_out[1]}, 9'h022);
    repeat (deb_n + det_n + 50) @(negedge clk);
    chk("inserted", {8'h00, insertion_status}, 9'h001);
    chk("applied", {1'b0, ctrl_out[1]}, 9'h05a);
    jack_detect_input = 1'b1;
    repeat (20) @(negedge clk);
    chk("removed", {8'h00, insertion_status}, 9'h000);
    jack_detect_input = 1'b0;
    hdr(8'h02);
    wb(8'h6c);
    u_mst.stop();
    jack_detect_input = 1'b1;
    repeat (20) @(negedge clk);
    chk("released", {1'b0, ctrl_out[2]}, 9'h06c);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule // jack_i2c_slave_tb_top
